// File: psdd_pkg.sv
// Purpose: Constants for the push switch dim decoder
// Assumes: One mains cycle tick per period of the supply
// Notes: Thresholds are held in milliseconds and converted to mains cycles here
package psdd_pkg;

  // Mains timing base
  localparam int MAINS_PERIOD_MS = 20;
  localparam int IGNORE_MS = 40;
  localparam int SHORT_MAX_MS = 400;
  localparam int SYNC_MS = 10000;

  localparam int CNT_W = 9;
  typedef logic [CNT_W-1:0] psdd_cnt_t;

  // Least times round up to whole mains cycles
  localparam psdd_cnt_t IGNORE_CYC = psdd_cnt_t'((IGNORE_MS + MAINS_PERIOD_MS - 1) / MAINS_PERIOD_MS);
  localparam psdd_cnt_t SHORT_MAX_CYC = psdd_cnt_t'(SHORT_MAX_MS / MAINS_PERIOD_MS);
  localparam psdd_cnt_t SYNC_CYC = psdd_cnt_t'((SYNC_MS + MAINS_PERIOD_MS - 1) / MAINS_PERIOD_MS);
  localparam psdd_cnt_t CNT_ZERO = 9'h000;
  localparam psdd_cnt_t CNT_ONE = 9'h001;

  // Light level scale, 8 bits, full scale is 100 percent
  typedef logic [7:0] psdd_level_t;
  localparam psdd_level_t LEVEL_MAX = 8'hFF;
  localparam psdd_level_t LEVEL_MIN = 8'h01;
  localparam psdd_level_t LEVEL_SYNC = 8'h5E; // 37 percent of full scale
  localparam psdd_level_t LEVEL_RESET = 8'hFF;
  localparam psdd_level_t LEVEL_STEP = 8'h01;

  typedef enum logic [2:0] {
    ST_RESTORE = 3'b000,
    ST_IDLE = 3'b001,
    ST_PRESS = 3'b010,
    ST_ADJUST = 3'b011,
    ST_SYNCED = 3'b100
  } psdd_state_e;

endpackage : psdd_pkg

// File: psdd_decoder.sv
// Purpose: Sort push switch contacts on the dim input into ignore, toggle, dim and sync
// Assumes: dimPresent is a clean level, mainsTick one pulse per mains cycle, both synchronous
// Notes: rst stands for power return; the stored state is read back on the first cycle after it
`timescale 1ns/1ps

// Contract
// - Contacts under 40 ms are ignored; 40 to 400 ms toggle the lamp.
// - Contacts past 400 ms and under 10000 ms dim continuously while held.
// - Each new dimming run goes opposite to the previous run's direction.
// - Holding 10 s or more sets level 37 percent and direction downward.
// - Contact duration is measured by counting mains cycles on the dim input.
// - Level is saved to non-volatile storage on power loss and restored after.
// - A lamp that was off at power loss stays off after power returns.
module psdd_decoder (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic dimPresent,
  input wire logic mainsTick,
  input wire logic powerFail,
  input wire psdd_pkg::psdd_level_t nvLevelIn,
  input wire logic nvLampOnIn,
  output logic lampOn,
  output psdd_pkg::psdd_level_t lightLevel,
  output logic dimUp,
  output logic adjusting,
  output logic nvWrite,
  output psdd_pkg::psdd_level_t nvLevelOut,
  output logic nvLampOnOut
);
  import psdd_pkg::*;

  psdd_state_e state_r;
  psdd_cnt_t holdCnt_r;
  logic lampOn_r;
  psdd_level_t level_r;
  logic dimUp_r;
  logic nvWrite_r;
  psdd_level_t nvLevel_r;
  logic nvLampOn_r;
  logic adjusting_r;
  // Decoded contact events; dimStart and syncHit are shared by several processes, toggleHit feeds only the lamp
  logic dimStart;
  logic syncHit;
  logic toggleHit;

  // One dimming step in the given direction, clamped to the usable range
  function automatic psdd_level_t stepLevel(input psdd_level_t lvl, input logic up);
    psdd_level_t res;
    res = lvl;
    if (up) begin
      if (lvl < LEVEL_MAX) begin
        res = lvl + LEVEL_STEP;
      end
    end else begin
      if (lvl > LEVEL_MIN) begin
        res = lvl - LEVEL_STEP;
      end
    end
    return res;
  endfunction : stepLevel

  // Contact has outlived a short push while still closed: a dimming run starts
  function automatic logic isDimStart(input psdd_state_e st, input logic closed, input psdd_cnt_t cnt);
    logic hit;
    hit = 1'b0;
    if (st == ST_PRESS && closed && cnt > SHORT_MAX_CYC) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : isDimStart

  // Contact held through the whole sync time while dimming
  function automatic logic isSyncHit(input psdd_state_e st, input logic closed, input psdd_cnt_t cnt);
    logic hit;
    hit = 1'b0;
    if (st == ST_ADJUST && closed && cnt >= SYNC_CYC) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : isSyncHit

  // Released short push that lasted long enough not to be noise
  function automatic logic isToggle(input psdd_state_e st, input logic closed, input psdd_cnt_t cnt);
    logic hit;
    hit = 1'b0;
    if (st == ST_PRESS && !closed && cnt >= IGNORE_CYC) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : isToggle

  // One decode feeds state, lamp and direction so they cannot disagree on the edge
  assign dimStart = isDimStart(state_r, dimPresent, holdCnt_r);
  assign syncHit = isSyncHit(state_r, dimPresent, holdCnt_r);
  assign toggleHit = isToggle(state_r, dimPresent, holdCnt_r);

  // Contact timing and classification
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_RESTORE;
    end else begin
      case (state_r)
        ST_RESTORE: begin
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          if (dimPresent) begin
            state_r <= ST_PRESS;
          end
        end
        ST_PRESS: begin
          if (!dimPresent) begin
            state_r <= ST_IDLE;
          end else if (dimStart) begin
            state_r <= ST_ADJUST;
          end
        end
        ST_ADJUST: begin
          if (!dimPresent) begin
            state_r <= ST_IDLE;
          end else if (syncHit) begin
            state_r <= ST_SYNCED;
          end
        end
        ST_SYNCED: begin
          if (!dimPresent) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Mains cycles counted while the contact lasts; saturates so a stuck switch cannot wrap
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      holdCnt_r <= CNT_ZERO;
    end else if (state_r == ST_IDLE) begin
      holdCnt_r <= CNT_ZERO;
    end else if (dimPresent && mainsTick && holdCnt_r < SYNC_CYC) begin
      holdCnt_r <= holdCnt_r + CNT_ONE;
    end
  end

  // Lamp on/off: toggled on release, restored after power return
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lampOn_r <= 1'b0;
    end else if (state_r == ST_RESTORE) begin
      lampOn_r <= nvLampOnIn;
    end else if (toggleHit) begin
      lampOn_r <= !lampOn_r;
    end else if (dimStart) begin
      lampOn_r <= 1'b1; // Dimming from dark lights the lamp first
    end
  end

  // Light level: restored, stepped once per mains cycle while dimming, or forced by sync
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_r <= LEVEL_RESET;
    end else if (state_r == ST_RESTORE) begin
      level_r <= nvLevelIn;
    end else if (syncHit) begin
      level_r <= LEVEL_SYNC;
    end else if (state_r == ST_ADJUST && dimPresent && mainsTick) begin
      level_r <= stepLevel(level_r, dimUp_r);
    end
  end

  // Registered dimming flag, moved on the same edges as the state
  // so the output carries no decode glitch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adjusting_r <= 1'b0;
    end else if (dimStart) begin
      adjusting_r <= 1'b1;
    end else if (state_r == ST_ADJUST && (!dimPresent || syncHit)) begin
      adjusting_r <= 1'b0;
    end
  end

  // Dimming direction: flipped at each new run, forced down by sync
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dimUp_r <= 1'b0;
    end else if (dimStart) begin
      dimUp_r <= !dimUp_r;
    end else if (syncHit) begin
      dimUp_r <= 1'b0;
    end
  end

  // Snapshot to storage on power loss; each pulse lasts one cycle, and while powerFail stays high it repeats every second cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nvWrite_r <= 1'b0;
      nvLevel_r <= LEVEL_RESET;
      nvLampOn_r <= 1'b0;
    end else begin
      nvWrite_r <= powerFail && !nvWrite_r;
      if (powerFail && !nvWrite_r) begin
        nvLevel_r <= level_r;
        nvLampOn_r <= lampOn_r;
      end
    end
  end

  assign lampOn = lampOn_r;
  assign lightLevel = level_r;
  assign dimUp = dimUp_r;
  assign adjusting = adjusting_r;
  assign nvWrite = nvWrite_r;
  assign nvLevelOut = nvLevel_r;
  assign nvLampOnOut = nvLampOn_r;

endmodule : psdd_decoder

// File: psdd_decoder_chk.sv
// Purpose: Port checks for the dim decoder
// Assumes: One clock, sync reset
// Notes: Bound after the module
`timescale 1ns/1ps
module psdd_decoder_chk (
  input logic sys_clk,
  input logic rst,
  input logic dimPresent,
  input logic mainsTick,
  input logic powerFail,
  input psdd_pkg::psdd_level_t nvLevelIn,
  input logic nvLampOnIn,
  input logic lampOn,
  input psdd_pkg::psdd_level_t lightLevel,
  input logic dimUp,
  input logic adjusting,
  input logic nvWrite,
  input psdd_pkg::psdd_level_t nvLevelOut
);
  import psdd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Store write is a lone pulse carrying the level
  property p_pulse; nvWrite |=> !nvWrite; endproperty
  a_pulse: assert property (p_pulse) else $error("long store pulse");
  property p_snap; powerFail && !nvWrite |=> nvWrite && nvLevelOut == $past(lightLevel); endproperty
  a_snap: assert property (p_snap) else $error("bad snapshot");
  property p_back; $fell(rst) |=> lightLevel == $past(nvLevelIn) && lampOn == $past(nvLampOnIn); endproperty
  a_back: assert property (p_back) else $error("bad restore");
  // Dim runs: turn round on entry, step only on ticks
  property p_turn; $rose(adjusting) |-> lampOn && dimUp != $past(dimUp); endproperty
  a_turn: assert property (p_turn) else $error("bad dim entry");
  property p_hold; adjusting && !mainsTick && !$past(mainsTick) |=> $stable(lightLevel); endproperty
  a_hold: assert property (p_hold) else $error("level drift");
  property p_up; adjusting && dimPresent && mainsTick && dimUp && lightLevel != LEVEL_MAX
    |=> lightLevel == psdd_level_t'($past(lightLevel) + LEVEL_STEP); endproperty
  a_up: assert property (p_up) else $error("bad step");
  property p_sync; $fell(adjusting) && dimPresent && $past(dimPresent) |-> lightLevel == LEVEL_SYNC && !dimUp; endproperty
  a_sync: assert property (p_sync) else $error("bad sync");
  property p_idle; !dimPresent [*3] |-> !adjusting; endproperty
  a_idle: assert property (p_idle) else $error("dims when open");
endmodule : psdd_decoder_chk
bind psdd_decoder psdd_decoder_chk u_chk (.*);

// File: psdd_switch.sv
// Purpose: Push switch on the dim input
// Assumes: A mains cycle lasts 4 clocks here
// Notes: Open contact leaves the input low
`timescale 1ns/1ps
module psdd_switch (
  input logic sys_clk,
  input logic go,
  input logic [8:0] ticks,
  output logic dimPresent = 1'b0,
  output logic mainsTick = 1'b0
);
  int left;
  int ph;
  // Contact held for a whole count of mains cycles
  always @(posedge sys_clk) begin
    mainsTick <= 1'b0;
    if (go) begin
      dimPresent <= 1'b1;
      left = ticks;
      ph = 0;
    end else if (dimPresent) begin
      ph = ph + 1;
      if (ph == 4 && left == 0) dimPresent <= 1'b0;
      else if (ph == 4) begin
        mainsTick <= 1'b1;
        left = left - 1;
        ph = 0;
      end
    end
  end
endmodule : psdd_switch

// File: psdd_decoder_bench.sv
// Purpose: Contact classes, sync and power return
// Assumes: Switch model ticks every 4 clocks
// Notes: Expected state kept in lvl, on, up
`timescale 1ns/1ps
module psdd_decoder_bench;
  import psdd_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, go = 1'b0, powerFail = 1'b0, nvLampOnIn = 1'b0;
  logic dimPresent, mainsTick, lampOn, dimUp, adjusting, nvWrite, nvLampOnOut, on, up, sawAdj;
  logic [8:0] ticks = 9'h000;
  psdd_level_t nvLevelIn, lightLevel, nvLevelOut, lvl;
  int num_errors = 0, checks_done = 0, cycles = 0, n, seed = 32'hF1A66FCD;
  int seq [7] = '{1, 2, 20, 0, 0, 500, 30};
  psdd_decoder dut (.*);
  psdd_switch sw (.*);
  initial forever #10 sys_clk = ~sys_clk;
  // Level after k steps, clamped to the scale
  function automatic psdd_level_t stepped(psdd_level_t l, logic u, int k);
    int v;
    v = u ? l + k : l - k;
    v = v > LEVEL_MAX ? LEVEL_MAX : (v < LEVEL_MIN ? LEVEL_MIN : v);
    return psdd_level_t'(v);
  endfunction : stepped
  task chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Press for k mains cycles, wait bounded for release
  task push(input int k);
    ticks <= k[8:0];
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    sawAdj = 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 3000 && dimPresent; i++) begin
      @(posedge sys_clk);
      sawAdj = sawAdj | adjusting;
    end
    repeat (4) @(posedge sys_clk);
  endtask : push
  task complete_run();
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Ceiling well above the long sync hold
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    nvLevelIn <= psdd_level_t'(32'h40 + ($random(seed) & 32'h7F));
    nvLampOnIn <= 1'($random(seed));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    lvl = nvLevelIn;
    on = nvLampOnIn;
    up = 1'b0;
    chk(lampOn, on);
    chk(lightLevel, lvl);
    foreach (seq[i]) begin
      n = seq[i] != 0 ? seq[i] : 22 + {$random(seed)} % 40;
      push(n);
      if (n > 20) begin
        up = ~up;
        on = 1'b1;
        lvl = n >= 500 ? LEVEL_SYNC : stepped(lvl, up, n - 21);
        up = n >= 500 ? 1'b0 : up;
      end else if (n >= 2) on = ~on;
      chk(lampOn, on);
      chk(dimUp, up);
      chk(lightLevel, lvl);
      chk(sawAdj, n > 20);
      chk(adjusting, 1'b0);
    end
    powerFail <= 1'b1;
    @(posedge sys_clk);
    powerFail <= 1'b0;
    #1;
    chk(nvWrite, 1'b1);
    chk(nvLevelOut, lvl);
    chk(nvLampOnOut, on);
    @(posedge sys_clk);
    rst <= 1'b1;
    nvLevelIn <= nvLevelOut;
    nvLampOnIn <= nvLampOnOut;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(lampOn, on);
    chk(lightLevel, lvl);
    complete_run();
  end
endmodule : psdd_decoder_bench
